// [hdl/atw_adc_slave.sv]
// Contract
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - sda changes only while scl low
// - one scl pulse per bit, slave only
// - receiver acks each byte, ninth clock
// - ack holds sda low through scl high
// - master nak ends read, device releases
// - bytes continue while master acks
// - match device code and select bits
// - eighth bit one reads, zero writes
// - write address acked, no conversion
// - conversion starts at direction bit fall
// - device acks matching address low
// - first byte four zeros, upper nibble
// - master acks, then lower eight bits
// - next sample at result lsb fall
// - continuous mode, 18 clocks per result
// - result sent msb first, unsigned
// - conversion timed by own oscillator
// - completed result held in register
`timescale 1ns/100ps
`include "atw_defines.svh"

// small fifo between converter and serialiser
module atw_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
)
(
	input wire logic i_mclk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_flush, // drop all entries
	input wire logic i_in_valid, // write side valid
	output logic o_in_ready, // write side ready
	input wire logic [WIDTH-1:0] i_in_data, // write data
	output logic o_out_valid, // read side valid
	input wire logic i_out_ready, // read side ready
	output logic [WIDTH-1:0] o_out_data // read data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];

	// storage array needs no reset
	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_q[wr_q] <= i_in_data;
	end

	// pointers and fill level
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else if (i_flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= AW'(wr_q + 1'b1);
			if (pop)
				rd_q <= AW'(rd_q + 1'b1);
			cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		end
	end
endmodule

// two-wire read-only converter slave
module atw_adc_slave
	import atw_pkg::*;
(
	input wire logic i_mclk, // 40 MHz system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic [2:0] i_addr_sel, // address select bits 2..0
	input wire logic i_scl, // serial clock pin
	input wire logic i_sda, // serial data pin level
	output logic o_sda, // serial data drive value
	output logic o_sda_oe, // high while pulling sda
	input wire logic [11:0] i_sar_code, // analog front end code
	output logic o_sample, // sample switch closed
	output logic o_busy, // conversion in progress
	output logic [11:0] o_result // last completed result
);
	// pin synchronisers, first stage read only by second
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end
		else
		begin
			{scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
		end
	end

	// bus event decode on the sampled lines
	wire scl_rise = scl_s_q && !scl_p_q;
	wire scl_fall = !scl_s_q && scl_p_q;
	wire start_ev = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
	wire stop_ev = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

	atw_bus_state_type st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic hi_q, hi_d;
	logic rd_q, rd_d;
	logic mack_q, mack_d;
	logic drv_q, drv_d;
	logic conv_go;
	logic res_pop;

	// address compare after seven bits plus direction
	wire addr_match = (sh_q[7:4] == `ATW_DEV_CODE) && (sh_q[3:1] == i_addr_sel);
	wire dir_read = sh_q[0];
	wire last_bit = (bit_q == (`ATW_BYTE_BITS - 4'h1));

	// fifo output feeding the serialiser
	logic fifo_valid;
	atw_result_type fifo_word;
	atw_result_type conv_word;
	logic conv_valid;
	logic fifo_ready;
	wire [7:0] hi_byte = {4'h0, fifo_word.code[11:8]};
	wire [7:0] lo_byte = fifo_word.code[7:0];

	// bus state machine
	always_comb
	begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		tx_d = tx_q;
		hi_d = hi_q;
		rd_d = rd_q;
		mack_d = mack_q;
		drv_d = drv_q;
		conv_go = 1'b0;
		res_pop = 1'b0;
		if (start_ev)
		begin
			// restart abandons the bus transfer in flight; a running conversion carries on
			st_d = ST_ADDR;
			bit_d = '0;
			drv_d = 1'b0;
		end
		else if (stop_ev)
		begin
			st_d = ST_IDLE;
			drv_d = 1'b0;
		end
		else
		begin
			case (st_q)
			ST_IDLE, ST_IGNORE:
				drv_d = 1'b0;
			ST_ADDR:
			begin
				if (scl_rise)
				begin
					sh_d = {sh_q[6:0], sda_s_q};
					bit_d = bit_q + 4'h1;
				end
				if (scl_fall && bit_q == `ATW_BYTE_BITS)
				begin
					if (addr_match)
					begin
						st_d = ST_ADDR_ACK;
						drv_d = 1'b1;
						rd_d = dir_read;
						conv_go = dir_read;
					end
					else
						st_d = ST_IGNORE;
				end
			end
			ST_ADDR_ACK:
			begin
				// ack stays low over the whole high phase
				if (scl_fall)
				begin
					bit_d = '0;
					hi_d = 1'b1;
					tx_d = fifo_valid ? hi_byte : 8'h00; // first bit set up while scl low
					drv_d = rd_q && !tx_d[7];
					st_d = rd_q ? ST_TX : ST_IGNORE;
				end
			end
			ST_TX:
			begin
				// late load if the result was not ready at the ack fall; a slow master avoids it
				if (bit_q == 4'h0 && !scl_s_q && tx_q == 8'h00 && fifo_valid)
					tx_d = hi_q ? hi_byte : lo_byte;
				drv_d = !tx_d[7];
				if (scl_fall)
				begin
					tx_d = {tx_q[6:0], 1'b0};
					bit_d = bit_q + 4'h1;
					drv_d = !tx_q[6];
					if (last_bit)
					begin
						st_d = ST_TX_ACK;
						drv_d = 1'b0; // release for master ack
						if (!hi_q)
						begin
							res_pop = 1'b1;
							conv_go = 1'b1;
						end
					end
				end
			end
			ST_TX_ACK:
			begin
				drv_d = 1'b0;
				if (scl_rise)
					mack_d = !sda_s_q;
				if (scl_fall)
				begin
					bit_d = '0;
					tx_d = (mack_q && fifo_valid) ? (hi_q ? lo_byte : hi_byte) : 8'h00;
					drv_d = mack_q && !tx_d[7];
					hi_d = !hi_q;
					st_d = mack_q ? ST_TX : ST_IGNORE;
				end
			end
			default:
				st_d = ST_IDLE;
			endcase
		end
	end

	// bus registers
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_q <= ST_IDLE;
			bit_q <= '0;
			sh_q <= '0;
			tx_q <= '0;
			hi_q <= 1'b1;
			rd_q <= 1'b0;
			mack_q <= 1'b0;
			drv_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			hi_q <= hi_d;
			rd_q <= rd_d;
			mack_q <= mack_d;
			drv_q <= drv_d;
		end
	end

	// open drain: drive low only
	assign o_sda = 1'b0;
	assign o_sda_oe = drv_q;

	// converter timing from the system clock, not from scl
	atw_conv_state_type cv_q, cv_d;
	logic [9:0] cnt_q, cnt_d;
	logic [11:0] res_q;
	logic cap_q;
	always_comb
	begin
		cv_d = cv_q;
		cnt_d = cnt_q;
		case (cv_q)
		CV_IDLE:
			if (conv_go && fifo_ready)
			begin
				cv_d = CV_ACQ;
				cnt_d = 10'(`ATW_ACQ_CYC - 1);
			end
		CV_ACQ:
			if (cnt_q == '0)
			begin
				cv_d = CV_CONV;
				cnt_d = 10'(`ATW_CONV_CYC - 1);
			end
			else
				cnt_d = cnt_q - 10'h001;
		CV_CONV:
			if (cnt_q == '0)
				cv_d = CV_IDLE;
			else
				cnt_d = cnt_q - 10'h001;
		default:
			cv_d = CV_IDLE;
		endcase
	end
	wire conv_done = (cv_q == CV_CONV) && (cnt_q == '0);

	// converter registers and result holding register
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cv_q <= CV_IDLE;
			cnt_q <= '0;
			res_q <= `ATW_RES_RST;
			cap_q <= 1'b0;
		end
		else
		begin
			cv_q <= cv_d;
			cnt_q <= cnt_d;
			cap_q <= conv_done;
			if (conv_done)
				res_q <= i_sar_code;
		end
	end

	assign conv_valid = cap_q;
	assign conv_word.code = res_q;

	// result queue; the bus state machine retries a missed load only until the first scl rise of the byte
	atw_fifo #(.WIDTH(`ATW_RES_BITS), .DEPTH(`ATW_FIFO_DEPTH)) atw_fifo_inst
	(
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_flush(start_ev),
		.i_in_valid(conv_valid),
		.o_in_ready(fifo_ready),
		.i_in_data(conv_word),
		.o_out_valid(fifo_valid),
		.i_out_ready(res_pop),
		.o_out_data(fifo_word)
	);

	assign o_sample = (cv_q == CV_ACQ);
	assign o_busy = (cv_q != CV_IDLE);
	assign o_result = res_q;
endmodule

// [hdl/atw_defines.svh]
`ifndef ATW_DEFINES_SVH
`define ATW_DEFINES_SVH

// fixed device code in the top nibble of the address byte (arbitrary value)
`define ATW_DEV_CODE 4'h5
// default address select bits
`define ATW_ADDR_SEL_RST 3'h5
// acquisition and conversion times in nanoseconds
`define ATW_ACQ_NS 1120
`define ATW_CONV_NS 8960
`define ATW_CLK_NS 25
// cycle counts, least times rounded up
`define ATW_ACQ_CYC ((`ATW_ACQ_NS + `ATW_CLK_NS - 1) / `ATW_CLK_NS)
`define ATW_CONV_CYC ((`ATW_CONV_NS + `ATW_CLK_NS - 1) / `ATW_CLK_NS)
// bits per byte on the wire, and result width
`define ATW_BYTE_BITS 4'h8
`define ATW_RES_BITS 12
// reset value of the result holding register
`define ATW_RES_RST 12'h000
// fifo depth in front of the serialiser
`define ATW_FIFO_DEPTH 4

`endif

// [hdl/atw_pkg.sv]
package atw_pkg;

	// bus side state
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} atw_bus_state_type;

	// converter sequencing state
	typedef enum logic [1:0] {
		CV_IDLE,
		CV_ACQ,
		CV_CONV
	} atw_conv_state_type;

	// one completed conversion travelling to the serialiser
	typedef struct packed {
		logic [11:0] code;
	} atw_result_type;

endpackage

// [sim/atw_chk.sv]
`timescale 1ns/100ps
// pin level checks beside the converter slave
module atw_chk
(
	input wire logic i_mclk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_scl, // serial clock pin
	input wire logic i_sda, // resolved data level
	input wire logic o_sda, // drive value
	input wire logic o_sda_oe, // pull enable
	input wire logic [11:0] i_sar_code, // front end code
	input wire logic o_sample, // acquisition
	input wire logic o_busy, // conversion running
	input wire logic [11:0] o_result // holding register
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	logic scl_q;
	logic [3:0] age_q;
	// cycles since an scl fall, saturating so long idle stays bounded
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			scl_q <= 1'b1;
			age_q <= 4'hf;
		end
		else
		begin
			scl_q <= i_scl;
			age_q <= (scl_q && !i_scl) ? 4'h0 : age_q + 4'(age_q != 4'hf);
		end
	end
	AST_PULL_ONLY: assert property (o_sda == 1'b0)
		else $error("sda drive not low");
	AST_BUSY_AT_FALL: assert property ($rose(o_busy) |-> age_q inside {[4'h1:4'h8]})
		else $error("conversion not started at scl fall");
	AST_BUSY_SAMPLES: assert property ($rose(o_busy) |-> o_sample)
		else $error("conversion began without sampling");
	AST_SAMPLE_IN_BUSY: assert property (o_sample |-> o_busy)
		else $error("sampling outside busy");
	AST_ACQ_LEN: assert property ($rose(o_sample) |-> ##44 o_sample ##1 !o_sample)
		else $error("acquisition length wrong");
	AST_CONV_LEN: assert property ($fell(o_sample) |-> ##300 o_busy ##58 o_busy ##1 !o_busy)
		else $error("conversion length wrong");
	AST_RESULT_CAPTURE: assert property ($changed(o_result) |-> !o_busy && o_result == $past(i_sar_code))
		else $error("result not taken at conversion end");
	AST_STOP_RELEASE: assert property (i_scl && $rose(i_sda) |-> ##[1:6] !o_sda_oe)
		else $error("sda held after stop");
	AST_SDA_CHANGE_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda drive changed while scl high");
endmodule

bind atw_adc_slave atw_chk atw_chk_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(i_scl),
	.i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_sar_code(i_sar_code),
	.o_sample(o_sample), .o_busy(o_busy), .o_result(o_result));

// [sim/atw_mst.sv]
`timescale 1ns/100ps
// behavioural bus master, paced by the system clock, 200 ns scl period
module atw_mst
(
	input wire logic i_mclk, // system clock
	input wire logic i_sda, // resolved sda level
	output logic o_scl, // serial clock
	output logic o_sda_oe // high while pulling sda low
);
	// extra cycles per quarter period; 23 gives a 2500 ns scl period
	int slow = 0;
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// wait n clocks, then step just past the edge
	task automatic w(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// release, raise scl, then pull sda: doubles as repeated start
	task automatic start;
		w(2);
		o_sda_oe = 1'b0;
		w(2);
		o_scl = 1'b1;
		w(4);
		o_sda_oe = 1'b1;
		w(4);
		o_scl = 1'b0;
	endtask
	task automatic stop;
		w(2);
		o_sda_oe = 1'b1;
		w(2);
		o_scl = 1'b1;
		w(4);
		o_sda_oe = 1'b0;
		w(4);
	endtask
	// data moves mid low phase only, sampled just before the fall
	task automatic bit_io(input logic b, input int hold, output logic r);
		w(2 + slow);
		o_sda_oe = !b;
		w(2 + slow);
		o_scl = 1'b1;
		w(4 + 2 * slow + hold);
		r = i_sda;
		o_scl = 1'b0;
	endtask
	// byte plus ack; the ack high is stretched so a conversion can finish
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			bit_io(tx[i], (i == 0) ? 480 : 0, rx[i]);
	endtask
endmodule

// [sim/tb_atw_adc_slave.sv]
`timescale 1ns/100ps
// bench: master model on an open drain bus, front end code driven here
module tb_atw_adc_slave;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, m_oe, d_sda, d_oe, sample, busy;
	logic [11:0] sar = 12'h000;
	logic [2:0] sel = 3'h5;
	logic [11:0] result;
	logic [8:0] rx;
	logic r;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	wire sda = !(m_oe || d_oe); // pull-up wins when nobody pulls
	always #12.5 mclk = !mclk;
	atw_adc_slave atw_adc_slave_inst (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr_sel(sel),
		.i_scl(scl), .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe), .i_sar_code(sar),
		.o_sample(sample), .o_busy(busy), .o_result(result));
	atw_mst atw_mst_inst (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
	task end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask
	task x(input logic [8:0] t);
		atw_mst_inst.xfer(t, rx);
	endtask
	// hang guard, well above the expected run
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			end_sim;
		end
	end
	// read two results back to back, then nak
	task t_read;
		sar = 12'ha5c;
		atw_mst_inst.start;
		x(9'h0b7);
		chk("addr ack", 12'h000, 12'(rx[0]));
		chk("held result", 12'ha5c, result);
		x(9'h1fe);
		chk("high byte", 12'h00a, 12'(rx[8:1]));
		sar = 12'h3c1;
		x(9'h1fe);
		chk("low byte", 12'h05c, 12'(rx[8:1]));
		x(9'h1fe);
		chk("next high", 12'h003, 12'(rx[8:1]));
		x(9'h1ff);
		chk("next low", 12'h0c1, 12'(rx[8:1]));
		atw_mst_inst.w(8);
		chk("release", 12'h000, 12'(d_oe));
		atw_mst_inst.stop;
	endtask
	// poll, two misses, an aborted address, then a single read
	task t_poll;
		sar = 12'h777;
		atw_mst_inst.start;
		x(9'h0b5);
		chk("poll ack", 12'h000, 12'(rx[0]));
		chk("no conversion", 12'h3c1, result);
		chk("poll idle", 12'h000, 12'({d_sda, busy, sample}));
		atw_mst_inst.start;
		x(9'h0d7);
		chk("code miss", 12'h001, 12'(rx[0]));
		atw_mst_inst.start;
		x(9'h0b3);
		chk("select miss", 12'h001, 12'(rx[0]));
		atw_mst_inst.start;
		for (int i = 0; i < 4; i++)
			atw_mst_inst.bit_io(i[0], 0, r);
		atw_mst_inst.start;
		x(9'h0b7);
		chk("ack after abort", 12'h000, 12'(rx[0]));
		x(9'h1ff);
		chk("single high", 12'h007, 12'(rx[8:1]));
		atw_mst_inst.stop;
		chk("final result", 12'h777, result);
	endtask
	// one read at 400 kHz scl with other select bits, then back to the bench rate
	task t_fast;
		sar = 12'h9e4;
		sel = 3'h2;
		atw_mst_inst.slow = 23;
		atw_mst_inst.start;
		x(9'h0ab);
		chk("slow addr ack", 12'h000, 12'(rx[0]));
		x(9'h1fe);
		chk("slow high", 12'h009, 12'(rx[8:1]));
		x(9'h1ff);
		chk("slow low", 12'h0e4, 12'(rx[8:1]));
		atw_mst_inst.stop;
		chk("slow result", 12'h9e4, result);
		atw_mst_inst.slow = 0;
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		atw_mst_inst.w(3);
		t_read;
		t_poll;
		t_fast;
		end_sim;
	end
endmodule
